// File: sarrd_pkg.sv
package sarrd_pkg;

  // Clock period of the block in ns
  localparam int CLK_PERIOD_NS = 100;

  // Converter timing figures in ns
  localparam int BUSY_RISE_AMP_NS = 100;
  localparam int BUSY_RISE_BYP_NS = 30;
  localparam int CONV_TIME_AMP_NS = 1550;
  localparam int CONV_TIME_BYP_NS = 660;

  // Longest times round down, never below one cycle
  localparam int BUSY_RISE_AMP_CYC =
    (BUSY_RISE_AMP_NS / CLK_PERIOD_NS < 1) ? 1 : BUSY_RISE_AMP_NS / CLK_PERIOD_NS;
  localparam int BUSY_RISE_BYP_CYC =
    (BUSY_RISE_BYP_NS / CLK_PERIOD_NS < 1) ? 1 : BUSY_RISE_BYP_NS / CLK_PERIOD_NS;
  localparam int CONV_AMP_CYC =
    (CONV_TIME_AMP_NS / CLK_PERIOD_NS < 1) ? 1 : CONV_TIME_AMP_NS / CLK_PERIOD_NS;
  localparam int CONV_BYP_CYC =
    (CONV_TIME_BYP_NS / CLK_PERIOD_NS < 1) ? 1 : CONV_TIME_BYP_NS / CLK_PERIOD_NS;

  // Serial word layout
  localparam int RESULT_W = 14;
  localparam int CHAN_W   = 3;
  localparam int GAIN_W   = 3;
  localparam int WORD_W   = RESULT_W + CHAN_W + GAIN_W;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;

  // Control field positions
  localparam int CTRL_LP_BIT    = 0;
  localparam int CTRL_AMP_BIT   = 1;
  localparam int CTRL_CHAN_LSB  = 2;
  localparam int CTRL_GAIN_LSB  = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status field positions
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_STATE_LSB = 2;
  localparam int STAT_IDX_LSB   = 4;
  localparam int STAT_ACQ_LSB   = 16;

  typedef enum logic [1:0] {
    SARRD_ACQ,
    SARRD_DELAY,
    SARRD_CONV,
    SARRD_READ
  } sarrd_phase_type;

endpackage : sarrd_pkg

// File: sarrd_core.sv
// Functional notes
// - Busy rises within 100ns amp, 30ns bypass; the code takes one 100ns cycle after the synchronised fall in both modes.
// - Conversion ends within 1550ns or 660ns.
// - Channel bits then gain bits, MSB first.
// - Low power: start high time is acquisition.
// - Low power first sample is valid.
// - Busy high whole conversion, drops at end.
// - MSB at busy fall, next bits per rise.
// - Fewer extra edges give fewer indication bits.
`timescale 1ns/1ns
module sarrd_core
  import sarrd_pkg::*;
#(
  parameter int ACQ_CNT_W = 16
) (
  input  wire logic                sys_clk_in,
  input  wire logic                rst_in,
  input  wire logic                conv_start_n_in,
  input  wire logic                ser_clk_in,
  input  wire logic [RESULT_W-1:0] sar_result_in,
  output logic                     busy_out,
  output logic                     ser_data_out,
  output logic                     ser_data_oe_out,
  input  wire logic                wb_cyc_in,
  input  wire logic                wb_stb_in,
  input  wire logic                wb_we_in,
  input  wire logic [7:0]          wb_adr_in,
  input  wire logic [3:0]          wb_sel_in,
  input  wire logic [31:0]         wb_dat_in,
  output logic [31:0]              wb_dat_out,
  output logic                     wb_ack_out
);

  // Acquisition counter must fit status field and hold a useful span
  if (ACQ_CNT_W < 4 || ACQ_CNT_W > 16) begin : g_bad_acq_w
    $error("sarrd_core: ACQ_CNT_W must lie in 4..16");
  end

  typedef struct packed {
    logic                  cs_s1;
    logic                  cs_s2;
    logic                  cs_d;
    logic                  sck_s1;
    logic                  sck_s2;
    logic                  sck_d;
    sarrd_phase_type       phase;
    logic [4:0]            cnt;
    logic [4:0]            idx;
    logic [RESULT_W-1:0]   result;
    logic [CHAN_W+GAIN_W-1:0] ind;
    logic                  amp;
    logic                  busy;
    logic                  sdo;
    logic                  sdo_oe;
    logic [7:0]            ctrl;
    logic                  woken;
    logic                  valid;
    logic [ACQ_CNT_W-1:0]  acq_cnt;
    logic                  ack;
    logic [31:0]           rdat;
  } sarrd_state_type;

  sarrd_state_type st_r;
  sarrd_state_type st_nxt;

  logic             cs_fall;
  logic             cs_rise;
  logic             sck_rise;
  logic             wb_req;
  logic [WORD_W-1:0] word;

  // Edge detection only looks at the second and later sync stages
  assign cs_fall  = st_r.cs_d & ~st_r.cs_s2;
  assign cs_rise  = ~st_r.cs_d & st_r.cs_s2;
  assign sck_rise = ~st_r.sck_d & st_r.sck_s2;
  assign wb_req   = wb_cyc_in & wb_stb_in & ~st_r.ack;
  assign word     = {st_r.result, st_r.ind};

  // Next-state logic for the whole block
  always_comb begin
    st_nxt        = st_r;
    st_nxt.cs_s1  = conv_start_n_in;
    st_nxt.cs_s2  = st_r.cs_s1;
    st_nxt.cs_d   = st_r.cs_s2;
    st_nxt.sck_s1 = ser_clk_in;
    st_nxt.sck_s2 = st_r.sck_s1;
    st_nxt.sck_d  = st_r.sck_s2;
    // Output driver enables while the synchronised start level is low
    st_nxt.sdo_oe = ~st_r.cs_s2;

    // A high start pulse powers up the core, so later samples are good
    if (cs_rise) begin
      st_nxt.woken = 1'b1;
    end

    unique case (st_r.phase)
      SARRD_ACQ: begin
        if (st_r.cs_s2 && st_r.acq_cnt != '1) begin
          st_nxt.acq_cnt = st_r.acq_cnt + 1'b1;
        end
        if (cs_fall) begin
          st_nxt.amp   = st_r.ctrl[CTRL_AMP_BIT];
          st_nxt.ind   = {st_r.ctrl[CTRL_CHAN_LSB +: CHAN_W],
                          st_r.ctrl[CTRL_GAIN_LSB +: GAIN_W]};
          // Low power acquires fully during the high pulse
          st_nxt.valid = st_r.ctrl[CTRL_LP_BIT] | st_r.woken;
          if ((st_r.ctrl[CTRL_AMP_BIT] ? BUSY_RISE_AMP_CYC : BUSY_RISE_BYP_CYC) <= 1) begin
            st_nxt.phase = SARRD_CONV;
            st_nxt.busy  = 1'b1;
            st_nxt.cnt   = st_r.ctrl[CTRL_AMP_BIT] ? 5'(CONV_AMP_CYC) : 5'(CONV_BYP_CYC);
          end else begin
            st_nxt.phase = SARRD_DELAY;
            st_nxt.cnt   = st_r.ctrl[CTRL_AMP_BIT] ? 5'(BUSY_RISE_AMP_CYC - 1)
                                                   : 5'(BUSY_RISE_BYP_CYC - 1);
          end
        end
      end
      SARRD_DELAY: begin
        if (st_r.cnt <= 5'h01) begin
          st_nxt.phase = SARRD_CONV;
          st_nxt.busy  = 1'b1;
          st_nxt.cnt   = st_r.amp ? 5'(CONV_AMP_CYC) : 5'(CONV_BYP_CYC);
        end else begin
          st_nxt.cnt = st_r.cnt - 5'h01;
        end
      end
      SARRD_CONV: begin
        // Serial clock is ignored here; the host keeps it low
        if (st_r.cnt <= 5'h01) begin
          st_nxt.phase  = SARRD_READ;
          st_nxt.busy   = 1'b0;
          st_nxt.result = sar_result_in;
          st_nxt.idx    = 5'h00;
          st_nxt.sdo    = sar_result_in[RESULT_W-1];
        end else begin
          st_nxt.cnt = st_r.cnt - 5'h01;
        end
      end
      SARRD_READ: begin
        if (sck_rise && st_r.idx < 5'(WORD_W)) begin
          st_nxt.idx = st_r.idx + 5'h01;
          // Past the last indication bit the line rests low
          st_nxt.sdo = (st_r.idx + 5'h01 < 5'(WORD_W))
                       ? word[5'(WORD_W - 1) - (st_r.idx + 5'h01)] : 1'b0;
        end
        if (cs_rise) begin
          st_nxt.phase   = SARRD_ACQ;
          st_nxt.acq_cnt = '0;
        end
      end
    endcase

    // Classic Wishbone slave, one wait state, unmapped reads give zero
    st_nxt.ack = wb_req;
    if (wb_req) begin
      st_nxt.rdat = 32'h0000_0000;
      if (wb_we_in) begin
        if (wb_adr_in == CTRL_OFS && wb_sel_in[0]) begin
          st_nxt.ctrl = wb_dat_in[7:0];
        end
      end else begin
        unique case (wb_adr_in)
          CTRL_OFS:   st_nxt.rdat = {24'h00_0000, st_r.ctrl};
          STATUS_OFS: begin
            st_nxt.rdat[STAT_BUSY_BIT]            = st_r.busy;
            st_nxt.rdat[STAT_VALID_BIT]           = st_r.valid;
            st_nxt.rdat[STAT_STATE_LSB +: 2]      = st_r.phase;
            st_nxt.rdat[STAT_IDX_LSB +: 5]        = st_r.idx;
            st_nxt.rdat[STAT_ACQ_LSB +: ACQ_CNT_W] = st_r.acq_cnt;
          end
          RESULT_OFS: st_nxt.rdat = {12'h000, st_r.ind, st_r.result};
          default:    st_nxt.rdat = 32'h0000_0000;
        endcase
      end
    end
  end

  // Single register stage for all state
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_r        <= '0;
      st_r.cs_s1  <= 1'b1;
      st_r.cs_s2  <= 1'b1;
      st_r.cs_d   <= 1'b1;
      st_r.phase  <= SARRD_ACQ;
      st_r.ctrl   <= CTRL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_out        = st_r.busy;
  assign ser_data_out    = st_r.sdo;
  assign ser_data_oe_out = st_r.sdo_oe;
  assign wb_dat_out      = st_r.rdat;
  assign wb_ack_out      = st_r.ack;

  // Bounds for the checks below
  localparam int CONV_MAX_CHK = CONV_AMP_CYC;
  localparam int BUSY_MAX_CHK = BUSY_RISE_AMP_CYC;

  sequence s_start_seen;
    st_r.phase == SARRD_ACQ && cs_fall;
  endsequence

  sequence s_busy_up;
    ##[1:BUSY_MAX_CHK] busy_out;
  endsequence

  chk_busy_rise_delay: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_start_seen |-> s_busy_up)
    else $error("busy did not rise after start");

  logic [4:0] busy_len;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      busy_len <= 5'h00;
    end else begin
      busy_len <= busy_out ? busy_len + 5'h01 : 5'h00;
    end
  end

  chk_conv_length_max: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    busy_len <= 5'(CONV_MAX_CHK))
    else $error("conversion ran too long");

  // Busy must stay up unbroken for the full count of the latched amp setting
  chk_busy_whole_conv: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $fell(busy_out) |-> busy_len == (st_r.amp ? 5'(CONV_AMP_CYC) : 5'(CONV_BYP_CYC)))
    else $error("busy not held for whole conversion");

  chk_msb_at_busy_fall: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $fell(busy_out) |-> ser_data_out == st_r.result[RESULT_W-1] && st_r.idx == 5'h00)
    else $error("msb not presented when busy fell");

  chk_edge_count_step: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_r.phase == SARRD_READ && sck_rise && !cs_rise && st_r.idx < 5'h13
    |=> st_r.idx == $past(st_r.idx) + 5'h01)
    else $error("edge count did not advance");

  chk_ind_order_bits: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_r.phase == SARRD_READ && st_r.idx == 5'(RESULT_W) |-> ser_data_out == st_r.ind[5])
    else $error("indication order wrong");

  chk_trail_low: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_r.phase == SARRD_READ && st_r.idx >= 5'(WORD_W) |-> !ser_data_out)
    else $error("data after last indication bit");

  chk_lp_acquire_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_r.phase == SARRD_ACQ && st_r.cs_s2 && st_r.cs_d && st_r.acq_cnt < 16'(4)
    |=> st_r.acq_cnt == $past(st_r.acq_cnt) + 1'b1)
    else $error("acquisition time not tracked");

  chk_lp_first_valid: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_start_seen ##0 st_r.ctrl[CTRL_LP_BIT] |=> st_r.valid)
    else $error("low power sample not marked valid");

  // Readout checks; the core result is taken from the input once per conversion
  sequence s_conv_last;
    st_r.phase == SARRD_CONV && st_r.cnt <= 5'h01;
  endsequence

  chk_read_after_conv: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s_conv_last |=> st_r.phase == SARRD_READ && !busy_out)
    else $error("readout did not follow conversion");

  chk_result_captured: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $fell(busy_out) |-> st_r.result == $past(sar_result_in))
    else $error("result not captured at busy fall");

  chk_busy_low_read: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_r.phase == SARRD_READ |-> !busy_out)
    else $error("busy high during readout");

  // Without a clock edge the host must see the same bit on every sample
  chk_sdo_holds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_r.phase == SARRD_READ && !sck_rise |=> $stable(ser_data_out))
    else $error("serial data moved without clock edge");

  chk_gain_after_chan: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_r.phase == SARRD_READ && st_r.idx == 5'(RESULT_W + CHAN_W)
    |-> ser_data_out == st_r.ind[GAIN_W-1])
    else $error("gain bits not after channel bits");

  chk_idx_saturate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_r.phase == SARRD_READ && st_r.idx == 5'(WORD_W) |=> st_r.idx == 5'(WORD_W))
    else $error("edge count ran past the word");

  chk_acq_restart: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    st_r.phase == SARRD_READ && cs_rise
    |=> st_r.phase == SARRD_ACQ && st_r.acq_cnt == '0)
    else $error("acquisition count not restarted");

endmodule : sarrd_core

// File: sarrd_host.sv
`timescale 1ns/1ns
// Host model: drives start and serial clock, collects the serial word
module sarrd_host
  import sarrd_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic busy_in,
  input  wire logic sdo_in,
  output logic      start_n_out,
  output logic      sck_out
);
  // Idle: start high, clock parked low outside frames
  initial begin
    start_n_out = 1'b1;
    sck_out     = 1'b0;
  end

  // One sample: high time, fall, wait busy, clock n bits out
  task automatic frame(input int n, input int hi, output logic [WORD_W-1:0] w,
                       output int rise_c, output int busy_c);
    w = '0;
    rise_c = 0;
    busy_c = 0;
    repeat (hi) @(posedge sys_clk_in);
    start_n_out <= 1'b0;
    while (busy_in !== 1'b1 && rise_c < 20) begin
      @(posedge sys_clk_in);
      rise_c++;
    end
    // Clock held low while converting; reading waits for busy low
    while (busy_in === 1'b1 && busy_c < 40) begin
      @(posedge sys_clk_in);
      busy_c++;
    end
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge sys_clk_in);
      w[WORD_W-1-i] = sdo_in;
      sck_out <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      sck_out <= 1'b0;
    end
    // Start rises with the last clock fall, the tightest close
    start_n_out <= 1'b1;
  endtask : frame
endmodule : sarrd_host

// File: tb.sv
`timescale 1ns/1ns
// Bench: host model on the link, Wishbone master on the registers
module tb
  import sarrd_pkg::*;
;
  localparam logic [7:0]          CTL_T [4] = '{8'h3D, 8'hE3, 8'h54, 8'hCE};
  localparam logic [RESULT_W-1:0] RES_T [4] = '{14'h2A5C, 14'h1FFF, 14'h2000, 14'h0001};
  localparam int                  N_T   [4] = '{17, 20, 14, 20};
  logic                sys_clk;
  logic                rst;
  logic                start_n;
  logic                sck;
  logic                busy;
  logic                sdo;
  logic                oe;
  logic                cyc;
  logic                stb;
  logic                we;
  logic                ack;
  logic [RESULT_W-1:0] result;
  logic [7:0]          adr;
  logic [3:0]          sel;
  logic [31:0]         wdat;
  logic [31:0]         rdat;
  logic [31:0]         q;
  logic [WORD_W-1:0]   w;
  logic [WORD_W-1:0]   exp;
  logic [WORD_W-1:0]   m;
  int                  rc;
  int                  bc;
  int                  error_cnt   = 0;
  int                  checks_done = 0;

  sarrd_core sarrd_core_inst (
    .sys_clk_in(sys_clk), .rst_in(rst), .conv_start_n_in(start_n),
    .ser_clk_in(sck), .sar_result_in(result), .busy_out(busy),
    .ser_data_out(sdo), .ser_data_oe_out(oe), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack));

  sarrd_host sarrd_host_inst (
    .sys_clk_in(sys_clk), .busy_in(busy), .sdo_in(sdo),
    .start_n_out(start_n), .sck_out(sck));

  // 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // Classic single cycle; held until ack is seen at an edge
  task automatic wb(input logic wr, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= wr;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge sys_clk);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  // Hang guard, far beyond the expected run
  initial begin
    #3000000;
    error_cnt++;
    $display("MISMATCH t=%0t watchdog", $time);
    end_of_test();
  end

  // Main sequence: one frame per mode, register checks around it
  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    result = '0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    wb(1'b0, CTRL_OFS, 4'hF, 32'h0, q);
    chk(q, {24'h0, CTRL_RESET});
    chk({31'h0, busy}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      result <= RES_T[i];
      wb(1'b1, CTRL_OFS, 4'h1, {24'h0, CTL_T[i]}, q);
      wb(1'b0, CTRL_OFS, 4'hF, 32'h0, q);
      chk(q, {24'h0, CTL_T[i]});
      sarrd_host_inst.frame(N_T[i], CTL_T[i][0] ? 5 : 2, w, rc, bc);
      chk({31'h0, oe}, 32'h1);
      exp = {RES_T[i], CTL_T[i][4:2], CTL_T[i][7:5]};
      m = {WORD_W{1'b1}} << (WORD_W - N_T[i]);
      chk({12'h0, w & m}, {12'h0, exp & m});
      chk(32'(bc), 32'(CTL_T[i][1] ? CONV_AMP_CYC : CONV_BYP_CYC));
      chk({31'h0, rc <= 6}, 32'h1);
      wb(1'b1, RESULT_OFS, 4'hF, 32'hFFFFFFFF, q);
      wb(1'b0, RESULT_OFS, 4'hF, 32'h0, q);
      chk(q, {12'h0, exp[5:0], exp[19:6]});
      wb(1'b0, STATUS_OFS, 4'hF, 32'h0, q);
      chk({22'h0, q[31:16] != 16'h0, q[8:0]}, {22'h0, 1'b1, 5'(N_T[i]), 4'h2});
      chk({31'h0, oe}, 32'h0);
    end
    wb(1'b1, CTRL_OFS, 4'hE, 32'hFF, q);
    wb(1'b0, CTRL_OFS, 4'hF, 32'h0, q);
    chk(q, {24'h0, CTL_T[3]});
    wb(1'b0, 8'h0C, 4'hF, 32'h0, q);
    chk(q, 32'h0);
    end_of_test();
  end
endmodule : tb
